// ==== verilog/ldst_pkg.sv ====
package ldst_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses on the APB slave)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] LAST_ADDR_OFS = 8'h08;
    localparam logic [7:0] COUNT_OFS = 8'h0c;
    localparam logic [7:0] LOWREG_BASE_OFS = 8'h20;
    localparam logic [7:0] STACK_PTR_OFS = 8'h40;

    // Field positions and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_BADOP_BIT = 1;
    localparam int STATUS_LOADPEND_BIT = 2;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam int COUNT_W = 16;

    // ----------------------------------------------------------------
    // Instruction fields
    // ----------------------------------------------------------------
    localparam int DATA_LSB = 0;
    localparam int BASE_LSB = 3;
    localparam int OFS5_LSB = 6;
    localparam int DIR_BIT = 11;
    localparam int SIZE_BIT = 12;
    localparam int SP_DATA_LSB = 8;
    localparam int SP_OFS_LSB = 0;
    localparam logic [2:0] OPC_IMM = 3'h3;
    localparam logic [3:0] OPC_HALF = 4'h8;
    localparam logic [3:0] OPC_STACK = 4'h9;
    localparam int WORD_SHIFT = 2;
    localparam int HALF_SHIFT = 1;
    localparam int OFS_W = 10;

    // Nominal cycles per operation, matching the full-width equivalents
    localparam int STORE_CYCLES = 2;
    localparam int LOAD_CYCLES = 3;

    typedef enum logic [1:0]
    {
        SZ_BYTE = 2'h0,
        SZ_HALF = 2'h1,
        SZ_WORD = 2'h2
    } size_e;

endpackage

// ==== verilog/dec_if.sv ====
`timescale 1ns/1ps

// Decoded fields handed from the field decoder to the execute logic
interface dec_if;
    logic op_valid;
    logic is_load;
    ldst_pkg::size_e size;
    logic [2:0] data_sel;
    logic [2:0] base_reg_sel;
    logic use_sp;
    logic [ldst_pkg::OFS_W-1:0] offset;

    modport producer (output op_valid, is_load, size, data_sel, base_reg_sel, use_sp, offset);
    modport consumer (input op_valid, is_load, size, data_sel, base_reg_sel, use_sp, offset);
endinterface

// ==== verilog/instr_field_decode.sv ====
`timescale 1ns/1ps

module instr_field_decode
(
    input wire logic [15:0] instr,
    dec_if.producer dec
);
    import ldst_pkg::*;

    // ----------------------------------------------------------------
    // Format recognition
    // ----------------------------------------------------------------
    wire logic is_imm = (instr[15:13] == OPC_IMM);
    wire logic is_half = (instr[15:12] == OPC_HALF);
    wire logic is_stack = (instr[15:12] == OPC_STACK);
    wire logic [4:0] short_offset_field = instr[OFS5_LSB +: 5];
    wire logic [7:0] scaled_word_offset_field = instr[SP_OFS_LSB +: 8];
    wire logic byte_sel = instr[SIZE_BIT];

    // Offsets: word scaled by four, half by two, byte unscaled
    wire logic [OFS_W-1:0] ofs_word = {3'h0, short_offset_field, 2'h0};
    wire logic [OFS_W-1:0] ofs_half = {4'h0, short_offset_field, 1'h0};
    wire logic [OFS_W-1:0] ofs_byte = {5'h0, short_offset_field};
    wire logic [OFS_W-1:0] ofs_stack = {scaled_word_offset_field, 2'h0};

    // Field routing; direction is bit 11 in every format handled here
    assign dec.op_valid = is_imm | is_half | is_stack;
    assign dec.is_load = instr[DIR_BIT];
    assign dec.size = is_half ? SZ_HALF :
                      (is_imm && byte_sel) ? SZ_BYTE : SZ_WORD;
    assign dec.data_sel = is_stack ? instr[SP_DATA_LSB +: 3] : instr[DATA_LSB +: 3];
    assign dec.base_reg_sel = instr[BASE_LSB +: 3];
    assign dec.use_sp = is_stack;
    assign dec.offset = is_stack ? ofs_stack :
                        is_half ? ofs_half :
                        byte_sel ? ofs_byte : ofs_word;

endmodule

// ==== verilog/byte_lane_steer.sv ====
`timescale 1ns/1ps

module byte_lane_steer
(
    input wire logic [1:0] addr_lo,
    input wire ldst_pkg::size_e size,
    input wire logic [31:0] store_src,
    input wire logic [31:0] rdata,
    output logic [31:0] wdata,
    output logic [3:0] be,
    output logic [31:0] load_value
);
    import ldst_pkg::*;

    // ----------------------------------------------------------------
    // Little-endian lane placement
    // ----------------------------------------------------------------
    // Sub-word stores replicate the data so any lane carries it
    wire logic [3:0] be_byte = 4'h1 << addr_lo;
    wire logic [3:0] be_half = addr_lo[1] ? 4'hc : 4'h3;
    wire logic [31:0] lane_shift = rdata >> {addr_lo, 3'h0};
    wire logic [31:0] half_shift = addr_lo[1] ? {16'h0, rdata[31:16]} : {16'h0, rdata[15:0]};

    assign be = (size == SZ_BYTE) ? be_byte : (size == SZ_HALF) ? be_half : 4'hf;
    assign wdata = (size == SZ_BYTE) ? {4{store_src[7:0]}} :
                   (size == SZ_HALF) ? {2{store_src[15:0]}} : store_src;
    // Loads zero-fill above the accessed width
    assign load_value = (size == SZ_BYTE) ? {24'h0, lane_shift[7:0]} :
                        (size == SZ_HALF) ? half_shift : rdata;

endmodule

// ==== verilog/ldst_imm_exec.sv ====
`timescale 1ns/1ps

// How it works
// - Data register bits 2:0, base bits 5:3, five-bit offset bits 10:6.
// - Bit 11 clear stores to memory, set loads from memory.
// - Bit 12 clear moves a word, set moves one byte.
// - Word access address is base plus offset; whole register moves.
// - Byte store writes only the low byte at base plus offset.
// - Byte load reads the byte at base plus offset into register.
// - Word offset field shifted left by two, up to seven bits.
// - Byte offset field used unscaled.
// - Each op takes the cycles of its full-width load or store.
// - Half-word op moves 16 bits between a low register and memory.
// - Half store writes bits 15:0 of the source at base plus offset.
// - Half load fills bits 15:0 and clears bits 31:16.
// - Half offset field shifted left by one, up to six bits.
// - Stack format moves a word, base always the stack pointer.
// - Stack offset is unsigned, added to the stack pointer, up to 1020.
// - Stack store writes the whole source register.
// - Stack load reads the word into the destination register.
// - Stack offset field shifted left by two, up to ten bits.
module ldst_imm_exec
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ldst_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [3:0] mem_be,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);
    import ldst_pkg::*;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_MEM = 3'b010,
        ST_WB = 3'b100
    } exec_state_e;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    exec_state_e state_q;
    exec_state_e state_d;
    logic [31:0] low_register_q [8];
    logic [31:0] stack_pointer_q;
    logic [31:0] ctrl_q;
    logic badop_q;
    logic [COUNT_W-1:0] count_q;
    logic [31:0] last_addr_q;
    logic is_load_q;
    size_e size_q;
    logic [2:0] data_sel_q;
    logic [31:0] load_q;
    logic instr_ready_q;
    logic mem_req_q;
    logic mem_we_q;
    logic [31:0] mem_addr_q;
    logic [3:0] mem_be_q;
    logic [31:0] mem_wdata_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    dec_if dec_bus ();

    instr_field_decode u_decode
    (
        .instr(instr),
        .dec(dec_bus)
    );

    // Base and address: stack pointer or low register, plus zero-extended offset
    wire logic [31:0] base_value = dec_bus.use_sp ? stack_pointer_q :
                                   low_register_q[dec_bus.base_reg_sel];
    wire logic [31:0] ofs_ext = {{(32 - OFS_W){1'b0}}, dec_bus.offset};
    wire logic [31:0] addr_d = base_value + ofs_ext;
    wire logic [31:0] store_src = low_register_q[dec_bus.data_sel];

    // ----------------------------------------------------------------
    // Byte lanes
    // ----------------------------------------------------------------
    // One steering instance serves both directions: it sees the decode
    // while idle and the latched access while the memory answers.
    wire logic idle = (state_q == ST_IDLE);
    wire logic [1:0] lane_addr = idle ? addr_d[1:0] : mem_addr_q[1:0];
    wire size_e lane_size = idle ? dec_bus.size : size_q;
    logic [31:0] lane_wdata;
    logic [3:0] lane_be;
    logic [31:0] lane_load;

    byte_lane_steer u_lanes
    (
        .addr_lo(lane_addr),
        .size(lane_size),
        .store_src(store_src),
        .rdata(mem_rdata),
        .wdata(lane_wdata),
        .be(lane_be),
        .load_value(lane_load)
    );

    // ----------------------------------------------------------------
    // Execute sequencing
    // ----------------------------------------------------------------
    wire logic exec_en = ctrl_q[CTRL_EN_BIT];
    wire logic accept = ce && instr_valid && instr_ready_q;
    wire logic start_op = accept && dec_bus.op_valid;
    wire logic bad_op = accept && !dec_bus.op_valid;
    wire logic mem_done = ce && (state_q == ST_MEM) && mem_ack;
    wire logic wb_fire = ce && (state_q == ST_WB);
    // A store ends at the memory answer, a load one cycle later
    wire logic op_done = (mem_done && !is_load_q) || wb_fire;

    // Next state: store = issue + memory, load = issue + memory + writeback
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_op)
                begin
                    state_d = ST_MEM;
                end
            end
            ST_MEM:
            begin
                if (mem_ack)
                begin
                    state_d = is_load_q ? ST_WB : ST_IDLE;
                end
            end
            ST_WB:
            begin
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register; ce low freezes everything
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
        end
        else if (ce)
        begin
            state_q <= state_d;
        end
    end

    // Fetch handshake: ready only while idle and enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_ready_q <= 1'b0;
        end
        else if (ce)
        begin
            instr_ready_q <= (state_d == ST_IDLE) && exec_en;
        end
    end

    // Access latch: taken on issue, held until the memory answers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= REG_RST;
            mem_be_q <= 4'h0;
            mem_wdata_q <= REG_RST;
            is_load_q <= 1'b0;
            size_q <= SZ_WORD;
            data_sel_q <= 3'h0;
        end
        else if (start_op)
        begin
            mem_req_q <= 1'b1;
            mem_we_q <= !dec_bus.is_load;
            mem_addr_q <= addr_d;
            mem_be_q <= lane_be;
            mem_wdata_q <= lane_wdata;
            is_load_q <= dec_bus.is_load;
            size_q <= dec_bus.size;
            data_sel_q <= dec_bus.data_sel;
        end
        else if (mem_done)
        begin
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
        end
    end

    // Load data captured at the answer, already zero-filled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            load_q <= REG_RST;
        end
        else if (mem_done && is_load_q)
        begin
            load_q <= lane_load;
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    wire logic apb_setup = ce && psel && !penable;
    wire logic apb_wr = ce && psel && penable && pwrite && pready_q && !pslverr_q;
    wire logic hit_ctrl = (paddr == CTRL_OFS);
    wire logic hit_status = (paddr == STATUS_OFS);
    wire logic hit_last = (paddr == LAST_ADDR_OFS);
    wire logic hit_count = (paddr == COUNT_OFS);
    wire logic hit_reg = (paddr[7:5] == LOWREG_BASE_OFS[7:5]) && (paddr[1:0] == 2'h0);
    wire logic hit_sp = (paddr == STACK_PTR_OFS);
    wire logic mapped = hit_ctrl | hit_status | hit_last | hit_count | hit_reg | hit_sp;
    // Register writes would race a running operation, so they are refused
    wire logic reg_clash = pwrite && (hit_reg || hit_sp) && (state_d != ST_IDLE);
    wire logic [2:0] reg_idx = paddr[4:2];
    wire logic [31:0] status_word = {29'h0, !idle && is_load_q, badop_q, !idle};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_q :
                               hit_status ? status_word :
                               hit_last ? last_addr_q :
                               hit_count ? {{(32 - COUNT_W){1'b0}}, count_q} :
                               hit_reg ? low_register_q[reg_idx] :
                               hit_sp ? stack_pointer_q : 32'h0000_0000;

    // Zero wait states: answer decided at the setup edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= REG_RST;
        end
        else if (ce)
        begin
            pready_q <= apb_setup;
            pslverr_q <= apb_setup && (!mapped || reg_clash);
            prdata_q <= (apb_setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= CTRL_RST;
        end
        else if (apb_wr && hit_ctrl)
        begin
            ctrl_q <= {31'h0, pwdata[CTRL_EN_BIT]};
        end
    end

    // Unknown-opcode flag: write one clears, a new event wins the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            badop_q <= 1'b0;
        end
        else if (bad_op)
        begin
            badop_q <= 1'b1;
        end
        else if (apb_wr && hit_status && pwdata[STATUS_BADOP_BIT])
        begin
            badop_q <= 1'b0;
        end
    end

    // Completed-operation counter and last address; counter wraps
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count_q <= '0;
            last_addr_q <= REG_RST;
        end
        else
        begin
            if (apb_wr && hit_count)
            begin
                count_q <= '0;
            end
            else if (op_done)
            begin
                count_q <= count_q + 1'b1;
            end
            if (start_op)
            begin
                last_addr_q <= addr_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Writeback and software writes never meet: software is refused
    // unless the sequencer is idle for the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 8; i++)
            begin
                low_register_q[i] <= REG_RST;
            end
            stack_pointer_q <= REG_RST;
        end
        else if (wb_fire)
        begin
            low_register_q[data_sel_q] <= load_q;
        end
        else if (apb_wr && hit_reg)
        begin
            low_register_q[reg_idx] <= pwdata;
        end
        else if (apb_wr && hit_sp)
        begin
            stack_pointer_q <= pwdata;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign instr_ready = instr_ready_q;
    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_be = mem_be_q;
    assign mem_wdata = mem_wdata_q;

endmodule

// ==== verif/mem_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Data memory seen from the execute logic
// ----------------------------------------------------------------
module mem_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] stall,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ack
);
    logic [31:0] mem_q [64];
    logic [1:0] wait_q;
    logic [31:0] junk_q;
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [3:0] be_q;
    logic we_q;
    wire logic [5:0] idx = mem_addr[7:2];

    // Answer after the chosen stall; data only holds meaning with the answer
    assign mem_ack = mem_req && wait_q == stall;
    assign mem_rdata = mem_ack ? mem_q[idx] : junk_q;

    // Stall count, byte-lane writes and a record of the last access
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= 2'h0;
            junk_q <= 32'h5a5a_a5a5;
            foreach (mem_q[i])
                mem_q[i] <= 32'h0;
        end
        else
        begin
            junk_q <= ~junk_q;  // Idle data keeps moving so stale values never pass
            wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
            if (mem_ack)
            begin
                addr_q <= mem_addr;
                wdata_q <= mem_wdata;
                be_q <= mem_be;
                we_q <= mem_we;
                for (int b = 0; b < 4; b++)
                    if (mem_we && mem_be[b])
                        mem_q[idx][8*b +: 8] <= mem_wdata[8*b +: 8];
            end
        end
    end
endmodule

// ==== verif/ldst_imm_exec_chk.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checks for the load/store execute block
// ----------------------------------------------------------------
module ldst_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic [ldst_pkg::ADDR_W-1:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic instr_ready,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [3:0] mem_be,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack
);
    import ldst_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Opcode classes of the offered instruction
    wire logic take = instr_valid && instr_ready && ce;
    wire logic imm_op = instr[15:13] == OPC_IMM;
    wire logic half_op = instr[15:12] == OPC_HALF;
    wire logic sp_op = instr[15:12] == OPC_STACK;

    sequence accept_s;
        take && (imm_op || half_op || sp_op);
    endsequence
    sequence acked_s;
        mem_req && mem_ack && ce;
    endsequence

    accept_req_a: assert property (accept_s |=> mem_req && !instr_ready)
        else $error("no memory request after accept");
    store_dir_a: assert property (accept_s and !instr[DIR_BIT] |=> mem_we)
        else $error("store not marked as write");
    load_dir_a: assert property (accept_s and instr[DIR_BIT] |=> !mem_we)
        else $error("load marked as write");
    byte_lane_a: assert property (take && imm_op && instr[SIZE_BIT] |=> $onehot(mem_be))
        else $error("byte access enables other than one lane");
    word_lane_a: assert property (take && (imm_op && !instr[SIZE_BIT] || sp_op) |=> mem_be == 4'hf)
        else $error("word access without all lanes");
    half_lane_a: assert property (take && half_op |=> mem_be == 4'h3 || mem_be == 4'hc)
        else $error("half access with wrong lanes");
    hold_req_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
        else $error("request changed before answer");
    store_end_a: assert property (acked_s and mem_we |=> !mem_req && instr_ready)
        else $error("store did not finish in one cycle after answer");
    load_end_a: assert property (acked_s and !mem_we |=> !mem_req && !instr_ready ##1 instr_ready)
        else $error("load writeback timing wrong");
    apb_answer_a: assert property (psel && !penable && ce |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");
endmodule

bind ldst_imm_exec ldst_chk ldst_chk_inst (.pclk, .presetn, .ce, .psel, .penable, .paddr,
    .pready, .pslverr, .instr_valid, .instr, .instr_ready, .mem_req, .mem_we, .mem_addr,
    .mem_be, .mem_wdata, .mem_ack);

// ==== verif/compact_ldst_imm_offset_decode_bench.sv ====
`timescale 1ns/1ps

`define CHECK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module compact_ldst_imm_offset_decode_bench;
    import ldst_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, err;
    logic instr_valid, instr_ready, mem_req, mem_we, mem_ack;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic [15:0] instr;
    logic [3:0] mem_be;
    logic [1:0] stall;
    int fails, tests_run, n;

    ldst_imm_exec ldst_imm_exec_inst (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .instr_valid, .instr, .instr_ready,
        .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .mem_ack);
    mem_model mem_model_inst (.pclk, .presetn, .stall, .mem_req, .mem_we, .mem_addr,
        .mem_be, .mem_wdata, .mem_rdata, .mem_ack);

    // ----------------------------------------------------------------
    // Bus and instruction tasks
    // ----------------------------------------------------------------
    // One APB transfer; entered just after a rising edge
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        int k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++k < 20);
        if (k >= 20) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so a following call never reassigns psel in this step
        @(posedge pclk);
    endtask

    task automatic rreg(input int i, input logic [31:0] exp);
        apb(LOWREG_BASE_OFS + 8'(4*i), 1'b0, 32'h0);
        `CHECK(rd, exp)
    endtask

    // Offer an instruction; cyc counts edges from accept until ready again
    task automatic op(input logic [15:0] code, output int cyc);
        int k = 0;
        instr_valid <= 1'b1;
        instr <= code;
        do @(posedge pclk); while (instr_ready !== 1'b1 && ++k < 50);
        instr_valid <= 1'b0;
        cyc = 1;
        do @(posedge pclk); while (instr_ready !== 1'b1 && ++cyc < 50);
        if (k >= 50 || cyc >= 50) fails++;
    endtask

    // Run one op and compare the memory access that it made
    task automatic run(input logic [15:0] code, input logic [31:0] a, input logic [3:0] be,
        input logic [31:0] wd, input int cyc_exp);
        int cyc;
        op(code, cyc);
        `CHECK(cyc, cyc_exp)
        `CHECK(mem_model_inst.addr_q, a)
        `CHECK(mem_model_inst.we_q, !code[DIR_BIT])
        if (!code[DIR_BIT])
        begin
            `CHECK(mem_model_inst.be_q, be)
            `CHECK(mem_model_inst.wdata_q, wd)
        end
    endtask

    task test_done;
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Tests need about a hundred cycles; allow fifty times that
    initial
    begin
        repeat (5000) @(posedge pclk);
        fails++;
        test_done;
    end

    initial
    begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        instr_valid = 1'b0;
        instr = 16'h0;
        stall = 2'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(CTRL_OFS, 1'b0, 32'h0);
        `CHECK(rd, CTRL_RST)
        apb(8'h10, 1'b0, 32'h0);
        `CHECK(err, 1'b1)
        apb(8'h21, 1'b1, 32'h1);
        `CHECK(err, 1'b1)
        $display("test register map done");
        // Base and data set, destinations preset to ones to expose missing clears
        apb(LOWREG_BASE_OFS + 8'h04, 1'b1, 32'h0000_1000);
        apb(LOWREG_BASE_OFS + 8'h08, 1'b1, 32'h8765_4321);
        for (int i = 3; i < 7; i++)
            apb(LOWREG_BASE_OFS + 8'(4*i), 1'b1, 32'hffff_ffff);
        apb(STACK_PTR_OFS, 1'b1, 32'h0000_2000);
        run({3'b011, 2'b00, 5'd31, 3'd1, 3'd2}, 32'h107c, 4'hf, 32'h8765_4321, 2);
        run({3'b011, 2'b10, 5'd13, 3'd1, 3'd2}, 32'h100d, 4'h2, 32'h2121_2121, 2);
        run({4'h8, 1'b0, 5'd28, 3'd1, 3'd2}, 32'h1038, 4'h3, 32'h4321_4321, 2);
        stall <= 2'h2;
        run({4'h9, 1'b0, 3'd2, 8'hff}, 32'h23fc, 4'hf, 32'h8765_4321, 4);
        stall <= 2'h0;
        $display("test stores done");
        run({3'b011, 2'b01, 5'd31, 3'd1, 3'd3}, 32'h107c, 4'hf, 32'h0, 3);
        run({3'b011, 2'b11, 5'd13, 3'd1, 3'd4}, 32'h100d, 4'h2, 32'h0, 3);
        run({4'h8, 1'b1, 5'd28, 3'd1, 3'd5}, 32'h1038, 4'h3, 32'h0, 3);
        run({4'h9, 1'b1, 3'd6, 8'hff}, 32'h23fc, 4'hf, 32'h0, 3);
        rreg(3, 32'h8765_4321);
        rreg(4, 32'h0000_0021);
        rreg(5, 32'h0000_4321);
        rreg(6, 32'h8765_4321);
        $display("test loads done");
        // Four stores and four loads completed; last address is the stack load
        apb(COUNT_OFS, 1'b0, 32'h0);
        `CHECK(rd, 32'h0000_0008)
        apb(LAST_ADDR_OFS, 1'b0, 32'h0);
        `CHECK(rd, 32'h0000_23fc)
        // Clock enable low: an offered store must not be taken
        ce <= 1'b0;
        instr_valid <= 1'b1;
        instr <= 16'h9200;
        repeat (2) @(posedge pclk);
        `CHECK(instr_ready, 1'b1)
        instr_valid <= 1'b0;
        ce <= 1'b1;
        @(posedge pclk);
        $display("test clock enable done");
        op(16'he000, n);
        `CHECK(n, 1)
        apb(STATUS_OFS, 1'b0, 32'h0);
        `CHECK(rd[STATUS_BADOP_BIT], 1'b1)
        // Writing one to the flag clears it
        apb(STATUS_OFS, 1'b1, 32'h0000_0002);
        apb(STATUS_OFS, 1'b0, 32'h0);
        `CHECK(rd, 32'h0000_0000)
        $display("test unknown opcode done");
        test_done;
    end
endmodule
